// ===== interval_timer_regs.svh
// Constants of the five-channel interval timer: field positions,
// element codes, command codes and reset values.
// Included by bare name by the package-using design files.
`ifndef INTERVAL_TIMER_REGS_SVH
`define INTERVAL_TIMER_REGS_SVH
// Data pointer element codes inside a counter group
`define ELEM_MODE 2'h0
`define ELEM_LOAD 2'h1
`define ELEM_HOLD 2'h2
`define ELEM_ALARM 2'h3
// Group pointer code of the control group and its elements
`define GRP_CTRL 3'h7
`define CTRL_ELEM_MASTER 2'h0
`define CTRL_ELEM_ALARM1 2'h1
`define CTRL_ELEM_ALARM2 2'h2
`define CTRL_ELEM_STATUS 2'h3
// Command code fields
`define CMD_CLASS_MSB 7
`define CMD_CLASS_LSB 5
`define CMD_SUB_MSB 4
`define CMD_SUB_LSB 3
`define CMD_SEL_LSB 0
`define CMD_SUB_CLEAR 2'h0
`define CMD_SUB_SET 2'h1
`define CMD_SUB_STEP 2'h2
// Counter mode register fields
`define MODE_GMODE_MSB 2
`define MODE_GMODE_LSB 0
`define MODE_GPICK_MSB 4
`define MODE_GPICK_LSB 3
`define MODE_SRC_MSB 8
`define MODE_SRC_LSB 5
`define MODE_FALL_BIT 12
`define MODE_ALARM_BIT 13
`define MODE_REPEAT_BIT 14
// Master mode register fields
`define MASTER_DIV_MSB 3
`define MASTER_DIV_LSB 0
`define MASTER_SRC_MSB 7
`define MASTER_SRC_LSB 4
// Status register bit positions
`define STAT_OUT_LSB 1
`define STAT_BYTE_BIT 6
// Source codes: 0-4 source pins, 5-9 gate pins, 10-14 scaler taps
`define SRC_COUNT 15
`define SRC_DEFAULT 4'hA
// Scaler taps, one per frequency step
`define TAP_F1 0
`define TAP_F2 3
`define TAP_F3 7
`define TAP_F4 11
`define TAP_F5 15
// Reset values
`define MODE_RESET 16'h0000
`define MASTER_RESET 16'h0000
`define WORD_RESET 16'h0000
`endif

// ===== interval_timer_pkg.sv
// Types shared by the interval timer design files.
// Assumes the constants header is compiled alongside.
package interval_timer_pkg;
  typedef enum logic [2:0] {
    CMD_POINTER,
    CMD_ARM,
    CMD_LOAD,
    CMD_LOAD_ARM,
    CMD_DISARM_SAVE,
    CMD_SAVE,
    CMD_DISARM,
    CMD_OUTPUT
  } cmd_kind_t;
  typedef enum logic [2:0] {
    GATE_NONE,
    GATE_HIGH,
    GATE_LOW,
    GATE_RISE,
    GATE_FALL
  } gate_mode_t;
endpackage

// ===== timer_group.sv
// One counter group: mode, preset, capture and optional alarm
// registers, a 16-bit down counter and the group's output flop.
// Assumes all strobes are one-cycle pulses on the system clock.
`timescale 1ns/1ns
`include "interval_timer_regs.svh"
module timer_group #(
  parameter bit HAS_ALARM = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [14:0] src_i,
  input wire logic gate_own_i,
  input wire logic gate_up_i,
  input wire logic gate_dn_i,
  input wire logic wr_i,
  input wire logic [1:0] wr_elem_i,
  input wire logic wr_hi_i,
  input wire logic [7:0] wr_data_i,
  input wire logic arm_i,
  input wire logic disarm_i,
  input wire logic load_i,
  input wire logic save_i,
  input wire logic step_i,
  input wire logic set_out_i,
  input wire logic clr_out_i,
  output logic [15:0] mode_o,
  output logic [15:0] load_o,
  output logic [15:0] hold_o,
  output logic [15:0] alarm_o,
  output logic out_o
);
  logic [15:0] cnt_reg, cnt_next;
  logic armed_reg, trig_reg, src_prev_reg, gate_prev_reg;
  logic [3:0] src_sel;
  logic src_lvl, tick, gate_lvl, gate_ok, advance, tc, match;
  interval_timer_pkg::gate_mode_t gmode;

  // Merge one byte into a 16-bit register
  function automatic logic [15:0] put_byte(input logic [15:0] old, input logic hi,
                                           input logic [7:0] b);
    put_byte = hi ? {b, old[7:0]} : {old[15:8], b};
  endfunction

  assign src_sel = mode_o[`MODE_SRC_MSB:`MODE_SRC_LSB];
  assign src_lvl = (src_sel < 4'(`SRC_COUNT)) ? src_i[src_sel] : src_i[`SRC_DEFAULT];
  assign tick = mode_o[`MODE_FALL_BIT] ? (src_prev_reg & ~src_lvl) : (~src_prev_reg & src_lvl);

  // gate of own, next or previous group
  assign gate_lvl = (mode_o[`MODE_GPICK_MSB:`MODE_GPICK_LSB] == 2'h1) ? gate_up_i :
                    (mode_o[`MODE_GPICK_MSB:`MODE_GPICK_LSB] == 2'h2) ? gate_dn_i : gate_own_i;
  assign gmode = interval_timer_pkg::gate_mode_t'(mode_o[`MODE_GMODE_MSB:`MODE_GMODE_LSB]);

  always_comb begin
    case (gmode)
      interval_timer_pkg::GATE_HIGH: gate_ok = gate_lvl;
      interval_timer_pkg::GATE_LOW: gate_ok = ~gate_lvl;
      interval_timer_pkg::GATE_RISE,
      interval_timer_pkg::GATE_FALL: gate_ok = trig_reg;
      default: gate_ok = 1'b1;
    endcase
  end

  // Counting down; terminal count reloads from the preset
  assign advance = (armed_reg & tick & gate_ok) | step_i;
  assign tc = advance & ~load_i & (cnt_reg <= 16'h0001);
  always_comb begin
    cnt_next = cnt_reg;
    if (load_i) begin
      cnt_next = load_o;
    end else if (tc) begin
      cnt_next = load_o;
    end else if (advance) begin
      cnt_next = cnt_reg - 16'h0001;
    end
  end

  // compare against the value just reached
  assign match = HAS_ALARM & (cnt_next == alarm_o);

  // Counter, arming and gate trigger state
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= `WORD_RESET;
      armed_reg <= 1'b0;
      trig_reg <= 1'b0;
      src_prev_reg <= 1'b0;
      gate_prev_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      armed_reg <= arm_i | (armed_reg & ~disarm_i & ~(tc & ~mode_o[`MODE_REPEAT_BIT]));
      src_prev_reg <= src_lvl;
      gate_prev_reg <= gate_lvl;
      if ((gmode == interval_timer_pkg::GATE_RISE && gate_lvl && !gate_prev_reg) ||
          (gmode == interval_timer_pkg::GATE_FALL && !gate_lvl && gate_prev_reg)) begin
        trig_reg <= 1'b1;
      end else if (tc) begin
        trig_reg <= 1'b0;
      end
    end
  end

  // Host writes and capture; a save wins over a host write of hold
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_o <= `MODE_RESET;
      load_o <= `WORD_RESET;
      hold_o <= `WORD_RESET;
      alarm_o <= `WORD_RESET;
    end else begin
      if (wr_i && wr_elem_i == `ELEM_MODE) mode_o <= put_byte(mode_o, wr_hi_i, wr_data_i);
      if (wr_i && wr_elem_i == `ELEM_LOAD) load_o <= put_byte(load_o, wr_hi_i, wr_data_i);
      if (save_i) begin
        hold_o <= cnt_reg;
      end else if (wr_i && wr_elem_i == `ELEM_HOLD) begin
        hold_o <= put_byte(hold_o, wr_hi_i, wr_data_i);
      end
      if (HAS_ALARM && wr_i && wr_elem_i == `ELEM_ALARM) begin
        alarm_o <= put_byte(alarm_o, wr_hi_i, wr_data_i);
      end
    end
  end

  // alarm drives the pin when enabled
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_o <= 1'b0;
    end else if (HAS_ALARM && mode_o[`MODE_ALARM_BIT]) begin
      out_o <= match;
    end else if (set_out_i) begin
      out_o <= 1'b1;
    end else if (clr_out_i) begin
      out_o <= 1'b0;
    end else if (tc) begin
      out_o <= ~out_o;
    end
  end
endmodule

// ===== five_channel_interval_timer.sv
// Five-channel interval timer: host port, data pointer, frequency
// scaler, output divider and five counter groups.
// Assumes host strobes are synchronous to SYS_CLK_I and held at
// least one cycle; the data bus wire is resolved outside.
`timescale 1ns/1ns
`include "interval_timer_regs.svh"
module five_channel_interval_timer (
  input wire logic SYS_CLK_I,
  input wire logic ARST_N_I,
  input wire logic CHIP_SEL_I,
  input wire logic CTRL_SEL_I,
  input wire logic RD_I,
  input wire logic WR_I,
  input wire logic [7:0] HOST_DATA_LINES_I,
  output logic [7:0] HOST_DATA_LINES_O,
  output logic HOST_DATA_LINES_OE_N_O,
  input wire logic [4:0] GATE_I,
  input wire logic [4:0] SOURCE_I,
  output logic [4:0] COUNTER_OUT_O,
  output logic DIVIDED_FREQ_OUTPUT_O
);
  localparam int NGRP = 5;

  logic [2:0] ptr_grp_reg;
  logic [1:0] ptr_elem_reg;
  logic ptr_byte_reg;
  logic [15:0] master_reg;
  logic [15:0] scaler_reg;
  logic [3:0] div_cnt_reg;
  logic div_prev_reg;
  logic wr_prev_reg;
  logic rd_data_prev_reg;

  // Decode a command byte into its class
  function automatic interval_timer_pkg::cmd_kind_t cmd_kind(input logic [7:0] c);
    case (c[`CMD_CLASS_MSB:`CMD_CLASS_LSB])
      3'h0: cmd_kind = interval_timer_pkg::CMD_POINTER;
      3'h1: cmd_kind = interval_timer_pkg::CMD_ARM;
      3'h2: cmd_kind = interval_timer_pkg::CMD_LOAD;
      3'h3: cmd_kind = interval_timer_pkg::CMD_LOAD_ARM;
      3'h4: cmd_kind = interval_timer_pkg::CMD_DISARM_SAVE;
      3'h5: cmd_kind = interval_timer_pkg::CMD_SAVE;
      3'h6: cmd_kind = interval_timer_pkg::CMD_DISARM;
      default: cmd_kind = interval_timer_pkg::CMD_OUTPUT;
    endcase
  endfunction

  // Pick a source level from the 15-entry source set
  function automatic logic pick_src(input logic [14:0] s, input logic [3:0] sel);
    pick_src = (sel < 4'(`SRC_COUNT)) ? s[sel] : s[`SRC_DEFAULT];
  endfunction

  wire wr_cond = CHIP_SEL_I & ~RD_I & WR_I;
  wire rd_cond = CHIP_SEL_I & RD_I & ~WR_I;
  // One access per strobe: act on the first cycle of a write
  wire wr_start = wr_cond & ~wr_prev_reg;
  wire cmd_wr = wr_start & CTRL_SEL_I;
  wire data_wr = wr_start & ~CTRL_SEL_I;
  wire rd_data_now = rd_cond & ~CTRL_SEL_I;
  // A data read counts as done when its strobe drops
  wire rd_data_end = rd_data_prev_reg & ~rd_data_now;

  // Command fields
  interval_timer_pkg::cmd_kind_t kind;
  assign kind = cmd_kind(HOST_DATA_LINES_I);
  wire [4:0] cmd_sel = HOST_DATA_LINES_I[`CMD_SEL_LSB +: NGRP];
  wire [1:0] cmd_sub = HOST_DATA_LINES_I[`CMD_SUB_MSB:`CMD_SUB_LSB];
  wire [2:0] cmd_n = HOST_DATA_LINES_I[2:0];

  // Command classes as pulses
  wire do_ptr = cmd_wr & (kind == interval_timer_pkg::CMD_POINTER);
  wire do_arm = cmd_wr & ((kind == interval_timer_pkg::CMD_ARM) |
                          (kind == interval_timer_pkg::CMD_LOAD_ARM));
  wire do_load = cmd_wr & ((kind == interval_timer_pkg::CMD_LOAD) |
                           (kind == interval_timer_pkg::CMD_LOAD_ARM));
  wire do_disarm = cmd_wr & ((kind == interval_timer_pkg::CMD_DISARM) |
                             (kind == interval_timer_pkg::CMD_DISARM_SAVE));
  wire do_save = cmd_wr & ((kind == interval_timer_pkg::CMD_SAVE) |
                           (kind == interval_timer_pkg::CMD_DISARM_SAVE));
  wire do_out = cmd_wr & (kind == interval_timer_pkg::CMD_OUTPUT);
  // Codes with n of zero (sequencing control) touch no group
  wire do_set = do_out & (cmd_sub == `CMD_SUB_SET);
  wire do_clr = do_out & (cmd_sub == `CMD_SUB_CLEAR);
  wire do_step = do_out & (cmd_sub == `CMD_SUB_STEP);

  // Data port write targets in the control group
  wire ctrl_sel = (ptr_grp_reg == `GRP_CTRL);
  wire master_wr = data_wr & ctrl_sel & (ptr_elem_reg == `CTRL_ELEM_MASTER);
  wire alarm1_wr = data_wr & ctrl_sel & (ptr_elem_reg == `CTRL_ELEM_ALARM1);
  wire alarm2_wr = data_wr & ctrl_sel & (ptr_elem_reg == `CTRL_ELEM_ALARM2);
  // data access advances the byte bit
  wire byte_flip = data_wr | rd_data_end;

  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ptr_grp_reg <= 3'h0;
      ptr_elem_reg <= 2'h0;
      ptr_byte_reg <= 1'b0;
    end else if (do_ptr) begin
      ptr_grp_reg <= HOST_DATA_LINES_I[2:0];
      ptr_elem_reg <= HOST_DATA_LINES_I[4:3];
      ptr_byte_reg <= 1'b0;
    end else if (byte_flip) begin
      ptr_byte_reg <= ~ptr_byte_reg;
    end
  end

  // Strobe history for edge-based access
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      wr_prev_reg <= 1'b0;
      rd_data_prev_reg <= 1'b0;
    end else begin
      wr_prev_reg <= wr_cond;
      rd_data_prev_reg <= rd_data_now;
    end
  end

  // Master mode register, written a byte at a time
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      master_reg <= `MASTER_RESET;
    end else if (master_wr && ptr_byte_reg) begin
      master_reg[15:8] <= HOST_DATA_LINES_I;
    end else if (master_wr) begin
      master_reg[7:0] <= HOST_DATA_LINES_I;
    end
  end

  // free-running scaler on the system clock
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      scaler_reg <= 16'h0000;
    end else begin
      scaler_reg <= scaler_reg + 16'h0001;
    end
  end

  // common source set for groups and divider
  wire [4:0] taps = {scaler_reg[`TAP_F5], scaler_reg[`TAP_F4], scaler_reg[`TAP_F3],
                     scaler_reg[`TAP_F2], scaler_reg[`TAP_F1]};
  wire [14:0] src_set = {taps, GATE_I, SOURCE_I};

  // divider ratio 1 to 16, zero meaning 16
  wire div_lvl = pick_src(src_set, master_reg[`MASTER_SRC_MSB:`MASTER_SRC_LSB]);
  wire div_tick = div_lvl & ~div_prev_reg;
  wire [3:0] div_last = master_reg[`MASTER_DIV_MSB:`MASTER_DIV_LSB] - 4'h1;

  // Output is high for one source period in every N
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      div_cnt_reg <= 4'h0;
      div_prev_reg <= 1'b0;
      DIVIDED_FREQ_OUTPUT_O <= 1'b0;
    end else begin
      div_prev_reg <= div_lvl;
      if (div_tick) begin
        div_cnt_reg <= (div_cnt_reg >= div_last) ? 4'h0 : div_cnt_reg + 4'h1;
      end
      DIVIDED_FREQ_OUTPUT_O <= (div_cnt_reg == 4'h0);
    end
  end

  // Per-group readback words
  logic [15:0] g_mode [NGRP];
  logic [15:0] g_load [NGRP];
  logic [15:0] g_hold [NGRP];
  logic [15:0] g_alarm [NGRP];

  genvar gi;
  generate
    for (gi = 0; gi < NGRP; gi++) begin : grp
      // Pointer hits this group, or its alarm via the control group
      wire own_wr = data_wr & (ptr_grp_reg == 3'(gi + 1));
      wire alm_wr = (gi == 0) ? alarm1_wr : ((gi == 1) ? alarm2_wr : 1'b0);
      wire hit_n = (cmd_n == 3'(gi + 1));
      timer_group #(
        .HAS_ALARM((gi < 2) ? 1'b1 : 1'b0)
      ) u_group (
        .clk_i(SYS_CLK_I),
        .rst_n_i(ARST_N_I),
        .src_i(src_set),
        .gate_own_i(GATE_I[gi]),
        .gate_up_i(GATE_I[(gi + 1) % NGRP]),
        .gate_dn_i(GATE_I[(gi + NGRP - 1) % NGRP]),
        .wr_i(own_wr | alm_wr),
        .wr_elem_i(alm_wr ? `ELEM_ALARM : ptr_elem_reg),
        .wr_hi_i(ptr_byte_reg),
        .wr_data_i(HOST_DATA_LINES_I),
        .arm_i(do_arm & cmd_sel[gi]),
        .disarm_i(do_disarm & cmd_sel[gi]),
        .load_i(do_load & cmd_sel[gi]),
        .save_i(do_save & cmd_sel[gi]),
        .step_i(do_step & hit_n),
        .set_out_i(do_set & hit_n),
        .clr_out_i(do_clr & hit_n),
        .mode_o(g_mode[gi]),
        .load_o(g_load[gi]),
        .hold_o(g_hold[gi]),
        .alarm_o(g_alarm[gi]),
        .out_o(COUNTER_OUT_O[gi])
      );
    end
  endgenerate

  // Status: output pins and byte bit
  wire [7:0] status = {1'b0, ptr_byte_reg, COUNTER_OUT_O, 1'b0};

  // data port word picked by the pointer
  wire [2:0] gidx = ptr_grp_reg - 3'h1;
  wire grp_ok = (ptr_grp_reg >= 3'h1) && (ptr_grp_reg <= 3'(NGRP));
  logic [15:0] word;
  always_comb begin
    word = 16'h0000;
    if (ctrl_sel) begin
      if (ptr_elem_reg == `CTRL_ELEM_MASTER) begin
        word = master_reg;
      end else if (ptr_elem_reg == `CTRL_ELEM_ALARM1) begin
        word = g_alarm[0];
      end else if (ptr_elem_reg == `CTRL_ELEM_ALARM2) begin
        word = g_alarm[1];
      end else begin
        word = {8'h00, status};
      end
    end else if (grp_ok) begin
      if (ptr_elem_reg == `ELEM_MODE) begin
        word = g_mode[gidx];
      end else if (ptr_elem_reg == `ELEM_LOAD) begin
        word = g_load[gidx];
      end else if (ptr_elem_reg == `ELEM_HOLD) begin
        word = g_hold[gidx];
      end
    end
  end

  // low byte first on the 8-bit bus
  wire [7:0] data_byte = ptr_byte_reg ? word[15:8] : word[7:0];

  // drive only during a read, else release
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      HOST_DATA_LINES_O <= 8'h00;
      HOST_DATA_LINES_OE_N_O <= 1'b1;
    end else begin
      HOST_DATA_LINES_O <= CTRL_SEL_I ? status : data_byte;
      HOST_DATA_LINES_OE_N_O <= ~rd_cond;
    end
  end
endmodule

// ===== five_channel_interval_timer_props.sv
// Checker of the host port timing and status byte of the interval timer.
// Assumes one clock domain; bound to the top module below.
`timescale 1ns/1ns
module five_channel_interval_timer_chk (
  input wire logic SYS_CLK_I,
  input wire logic ARST_N_I,
  input wire logic CHIP_SEL_I,
  input wire logic CTRL_SEL_I,
  input wire logic RD_I,
  input wire logic WR_I,
  input wire logic [7:0] HOST_DATA_LINES_O,
  input wire logic HOST_DATA_LINES_OE_N_O,
  input wire logic [4:0] COUNTER_OUT_O
);
  logic rd_cond;
  logic stat_rd;
  // Read and status read as the pins decode them
  assign rd_cond = CHIP_SEL_I && RD_I && !WR_I;
  assign stat_rd = rd_cond && CTRL_SEL_I;
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!ARST_N_I);
  property p_oe_ans;
    rd_cond |=> !HOST_DATA_LINES_OE_N_O;
  endproperty
  a_oe_ans: assert property (p_oe_ans) else $error("bus idle after read");
  property p_oe_cs_off;
    !CHIP_SEL_I |=> HOST_DATA_LINES_OE_N_O;
  endproperty
  a_oe_cs_off: assert property (p_oe_cs_off) else $error("bus driven unselected");
  property p_oe_both;
    RD_I && WR_I |=> HOST_DATA_LINES_OE_N_O;
  endproperty
  a_oe_both: assert property (p_oe_both) else $error("bus driven on both strobes");
  property p_oe_write;
    CHIP_SEL_I && WR_I && !RD_I |=> HOST_DATA_LINES_OE_N_O;
  endproperty
  a_oe_write: assert property (p_oe_write) else $error("bus driven on write");
  property p_oe_stand;
    rd_cond [*3] |-> !HOST_DATA_LINES_OE_N_O;
  endproperty
  a_oe_stand: assert property (p_oe_stand) else $error("read answer dropped");
  property p_oe_end;
    $fell(rd_cond) |-> ##1 HOST_DATA_LINES_OE_N_O;
  endproperty
  a_oe_end: assert property (p_oe_end) else $error("bus held after read");
  property p_stat_frame;
    stat_rd |=> !HOST_DATA_LINES_O[7] && !HOST_DATA_LINES_O[0];
  endproperty
  a_stat_frame: assert property (p_stat_frame) else $error("status frame bits set");
  property p_stat_outs;
    stat_rd |=> HOST_DATA_LINES_O[5:1] == $past(COUNTER_OUT_O);
  endproperty
  a_stat_outs: assert property (p_stat_outs) else $error("status outputs wrong");
endmodule
bind five_channel_interval_timer five_channel_interval_timer_chk u_chk (
  .SYS_CLK_I(SYS_CLK_I), .ARST_N_I(ARST_N_I), .CHIP_SEL_I(CHIP_SEL_I),
  .CTRL_SEL_I(CTRL_SEL_I), .RD_I(RD_I), .WR_I(WR_I), .HOST_DATA_LINES_O(HOST_DATA_LINES_O),
  .HOST_DATA_LINES_OE_N_O(HOST_DATA_LINES_OE_N_O), .COUNTER_OUT_O(COUNTER_OUT_O));

// ===== host_bus_model.sv
// Host processor model on the timer's select, strobe and data pins.
// Assumes the device answers a read one edge after it sees it.
`timescale 1ns/1ns
module host_bus_model (
  input wire logic clk_i,
  input wire logic [7:0] dev_data_i,
  input wire logic dev_oe_n_i,
  output logic cs_o,
  output logic ctrl_o,
  output logic rd_o,
  output logic wr_o,
  output logic [7:0] bus_o
);
  logic [7:0] wdata = 8'h00;
  logic [7:0] last_bus = 8'h00;
  // Idle bus at start
  initial begin
    cs_o = 1'b0;
    ctrl_o = 1'b0;
    rd_o = 1'b0;
    wr_o = 1'b0;
  end
  // Released bus flips every cycle so stale data cannot pass
  assign bus_o = wr_o ? wdata : (!dev_oe_n_i ? dev_data_i : ~last_bus);
  always @(posedge clk_i) last_bus <= bus_o;
  task automatic xfer(input logic c, input logic s, input logic r, input logic w,
                      input logic [7:0] d, input int hold, output logic [7:0] q);
    @(posedge clk_i);
    cs_o <= c;
    ctrl_o <= s;
    rd_o <= r;
    wr_o <= w;
    wdata <= d;
    repeat (hold) @(posedge clk_i);
    @(posedge clk_i);
    q = bus_o;
    cs_o <= 1'b0;
    rd_o <= 1'b0;
    wr_o <= 1'b0;
    // Strobes must stay released before the next transfer
    repeat (2) @(posedge clk_i);
  endtask
endmodule

// ===== five_channel_interval_timer_tb_top.sv
// Testbench of the five-channel interval timer against a word model.
// Assumes host_bus_model drives the host pins and resolves the bus.
`timescale 1ns/1ns
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin bad_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module five_channel_interval_timer_tb_top;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [4:0] gate = 5'h00;
  logic [4:0] source = 5'h00;
  logic cs, ctrl, rd, wr, oe_n, divided_freq_output, divided_freq_output_q;
  logic [7:0] bus, dout, q;
  logic [4:0] cout;
  logic [4:0] mdl_out = 5'h00;
  int mdl_word[8][4];
  int mdl_cnt[6];
  int mdl_byte = 0;
  int ptr_g = 0;
  int ptr_e = 0;
  int divided_freq_output_rises = 0;
  int bad_count = 0;
  int check_count = 0;
  // System clock, 100 ns period
  always #50 sys_clk = ~sys_clk;
  // Rising edges of the divider output
  always @(posedge sys_clk) begin
    divided_freq_output_q <= divided_freq_output;
    if (divided_freq_output && !divided_freq_output_q) divided_freq_output_rises++;
  end
  five_channel_interval_timer DUT (
    .SYS_CLK_I(sys_clk), .ARST_N_I(arst_n), .CHIP_SEL_I(cs), .CTRL_SEL_I(ctrl), .RD_I(rd),
    .WR_I(wr), .HOST_DATA_LINES_I(bus), .HOST_DATA_LINES_O(dout),
    .HOST_DATA_LINES_OE_N_O(oe_n), .GATE_I(gate), .SOURCE_I(source),
    .COUNTER_OUT_O(cout), .DIVIDED_FREQ_OUTPUT_O(divided_freq_output));
  host_bus_model u_host (.clk_i(sys_clk), .dev_data_i(dout), .dev_oe_n_i(oe_n), .cs_o(cs),
    .ctrl_o(ctrl), .rd_o(rd), .wr_o(wr), .bus_o(bus));
  // Words that exist; groups 0 and 6 read zero
  function automatic bit live(int g, int e);
    return ((g >= 1 && g <= 5) || g == 7) && e <= 2;
  endfunction
  task automatic alarm_eval();
    for (int g = 1; g <= 2; g++)
      if (mdl_word[g][0][13]) mdl_out[g-1] = (mdl_cnt[g] == mdl_word[7][g]);
  endtask
  // Command write plus its model effect
  task automatic cmd(input logic [7:0] c);
    int n;
    n = c[2:0];
    u_host.xfer(1'b1, 1'b1, 1'b0, 1'b1, c, 0, q);
    if (c[7:5] == 3'h0) begin
      mdl_byte = 0;
      ptr_g = c[2:0];
      ptr_e = c[4:3];
    end
    for (int g = 1; g <= 5; g++) begin
      if (c[g-1] && c[7:5] inside {3'h2, 3'h3}) mdl_cnt[g] = mdl_word[g][1];
      if (c[g-1] && c[7:5] inside {3'h4, 3'h5}) mdl_word[g][2] = mdl_cnt[g];
    end
    if (c[7:5] == 3'h7 && c[4:3] == 2'h2) begin
      if (mdl_cnt[n] <= 1) begin
        mdl_cnt[n] = mdl_word[n][1];
        mdl_out[n-1] = !mdl_out[n-1];
      end else mdl_cnt[n]--;
    end
    if (c[7:5] == 3'h7 && !c[4]) mdl_out[n-1] = c[3];
    if (c[7:5] inside {3'h2, 3'h3, 3'h7}) alarm_eval();
  endtask
  // one data byte write at the pointer
  task automatic dwr(input logic [7:0] d, input int hold);
    u_host.xfer(1'b1, 1'b0, 1'b0, 1'b1, d, hold, q);
    if (live(ptr_g, ptr_e) && mdl_byte) mdl_word[ptr_g][ptr_e][15:8] = d;
    if (live(ptr_g, ptr_e) && !mdl_byte) mdl_word[ptr_g][ptr_e][7:0] = d;
    mdl_byte ^= 1;
  endtask
  // One data byte read at the pointer
  task automatic drd();
    logic [15:0] w;
    w = live(ptr_g, ptr_e) ? 16'(mdl_word[ptr_g][ptr_e]) : 16'h0000;
    u_host.xfer(1'b1, 1'b0, 1'b1, 1'b0, 8'h00, 1, q);
    `CHK(q, (mdl_byte ? w[15:8] : w[7:0]))
    mdl_byte ^= 1;
  endtask
  // pointer first, then low and high byte
  task automatic put_word(input int g, input int e, input logic [15:0] v);
    cmd({3'h0, e[1:0], g[2:0]});
    dwr(v[7:0], 0);
    dwr(v[15:8], 0);
  endtask
  task automatic get_word(input int g, input int e);
    cmd({3'h0, e[1:0], g[2:0]});
    drd();
    drd();
  endtask
  task automatic scan();
    for (int g = 0; g <= 7; g++)
      for (int e = 0; e <= 2; e++) get_word(g, e);
  endtask
  task automatic chk_status();
    u_host.xfer(1'b1, 1'b1, 1'b1, 1'b0, 8'h00, 1, q);
    `CHK(q, {1'b0, mdl_byte[0], mdl_out, 1'b0})
  endtask
  task automatic chk_out();
    repeat (2) @(negedge sys_clk);
    `CHK(cout, mdl_out)
  endtask
  // Pulses on one idle-low pin: codes 0-4 source pins, 5-9 gate pins
  // Whole-vector toggles keep the automatic index off the assigned target
  task automatic pulse(input int n, input int pin);
    repeat (2 * n) begin
      @(posedge sys_clk);
      if (pin < 5)
        source <= source ^ 5'(1 << pin);
      else
        gate <= gate ^ 5'(1 << (pin - 5));
      @(posedge sys_clk);
    end
  endtask
  task automatic test_done();
    $display("checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Cuts a hung run short
  initial begin
    repeat (30000) @(posedge sys_clk);
    $display("run took too long");
    bad_count++;
    test_done();
  end
  initial begin
    logic [15:0] p;
    void'($urandom(42304));
    repeat (5) @(posedge sys_clk);
    `CHK(cout, 5'h00)
    `CHK(oe_n, 1'b1)
    `CHK(divided_freq_output, 1'b0)
    arst_n <= 1'b1;
    scan();
    $display("test reset values done");
    for (int g = 1; g <= 5; g++) put_word(g, 1, 16'($urandom));
    put_word(7, 1, 16'($urandom));
    put_word(7, 2, 16'($urandom));
    put_word(5, 0, 16'($urandom) & 16'h1FE0);
    scan();
    $display("test word round trip done");
    // a held write is taken once
    cmd(8'h0B);
    dwr(8'h5A, 2);
    dwr(8'hC3, 0);
    get_word(3, 1);
    cmd(8'h0A);
    drd();
    chk_status();
    drd();
    chk_status();
    $display("test byte pointer done");
    cmd(8'h0C);
    u_host.xfer(1'b0, 1'b1, 1'b0, 1'b1, 8'h17, 0, q);
    u_host.xfer(1'b1, 1'b1, 1'b1, 1'b1, 8'h17, 0, q);
    u_host.xfer(1'b0, 1'b0, 1'b0, 1'b1, 8'hA5, 0, q);
    u_host.xfer(1'b1, 1'b0, 1'b1, 1'b1, 8'hA5, 0, q);
    drd();
    drd();
    $display("test refused cycles done");
    put_word(7, 1, 16'h0003);
    put_word(1, 0, 16'h2000);
    put_word(1, 1, 16'h0005);
    cmd(8'h41);
    cmd(8'hF1);
    cmd(8'hF1);
    chk_out();
    chk_status();
    cmd(8'hF1);
    chk_out();
    $display("test alarm done");
    cmd(8'hED);
    chk_out();
    chk_status();
    cmd(8'hE5);
    chk_out();
    $display("test set clear done");
    // count source pin edges, then capture
    p = 16'($urandom_range(16'hFFFF, 16'h0040));
    put_word(3, 0, 16'h0000);
    put_word(3, 1, p);
    cmd(8'h64);
    pulse(10, 0);
    mdl_cnt[3] -= 10;
    cmd(8'h84);
    get_word(3, 2);
    $display("test counting done");
    // own gate high lets the count through
    put_word(4, 0, 16'h0001);
    put_word(4, 1, 16'h0100);
    cmd(8'h68);
    pulse(6, 0);
    @(posedge sys_clk) gate[3] <= 1'b1;
    pulse(4, 0);
    mdl_cnt[4] -= 4;
    cmd(8'h88);
    get_word(4, 2);
    $display("test gating done");
    // group 2 counts falls of gate pin 1, gated low by gate pin 0
    put_word(2, 0, 16'h50D2);
    put_word(2, 1, 16'h0003);
    cmd(8'h42);
    cmd(8'h22);
    @(posedge sys_clk) gate[0] <= 1'b1;
    pulse(2, 6);
    @(posedge sys_clk) gate[0] <= 1'b0;
    pulse(4, 6);
    // Three, two, one, reload to three, two: one output toggle, still armed
    mdl_cnt[2] = 2;
    mdl_out[1] = 1'b1;
    chk_out();
    // Disarmed counter ignores edges; save then shows the held count
    cmd(8'hC2);
    pulse(2, 6);
    cmd(8'hA2);
    get_word(2, 2);
    chk_out();
    $display("test gate and source modes done");
    divided_freq_output_rises = 0;
    pulse(32, 0);
    repeat (4) @(negedge sys_clk);
    `CHK(divided_freq_output_rises, 2)
    // Ratio four: eight source edges give two output pulses
    put_word(7, 0, 16'h0004);
    divided_freq_output_rises = 0;
    pulse(8, 0);
    repeat (4) @(negedge sys_clk);
    `CHK(divided_freq_output_rises, 2)
    $display("test divider done");
    test_done();
  end
endmodule
